// ### include/cir_params.svh
/*
 constants of the codec two-wire control port: target address, register
 offsets, reset values, writable masks, field positions and timing.
 assumes it is included by bare name wherever a constant is needed.
*/
`ifndef CIR_PARAMS_SVH
`define CIR_PARAMS_SVH
// ----------------------------------------
// bus target address and counter limits
// ----------------------------------------
`define CIR_TARGET_ADDR 7'h12
`define CIR_NUM_REGS 6
`define CIR_WR_LAST 5'h05
`define CIR_RD_LAST 5'h0D
// ----------------------------------------
// register offsets
// ----------------------------------------
`define CIR_MUTE_AND_TIMING_RESET_CTRL 5'h00
`define CIR_CONVERTER_POWER_AND_PORT2_RATE 5'h01
`define CIR_SERIAL_FORMAT_CTRL 5'h02
`define CIR_DEEMPHASIS_CTRL 5'h03
`define CIR_PORT1_CLOCKING_CTRL 5'h04
`define CIR_INPUT_SELECT_AND_MUTE_TIME 5'h05
// ----------------------------------------
// reset values and writable bits
// ----------------------------------------
`define CIR_RST_VALUES {8'h10, 8'h00, 8'h50, 8'h0F, 8'h70, 8'h01}
`define CIR_WR_MASKS {8'h7F, 8'h77, 8'hF0, 8'h0F, 8'h77, 8'h07}
// ----------------------------------------
// field positions
// ----------------------------------------
`define CIR_B_TIMING_RESET_N 0
`define CIR_B_DAC1_UNMUTE 1
`define CIR_B_DAC2_UNMUTE 2
`define CIR_B_ADC_POWER_ON 4
`define CIR_B_DAC1_POWER_ON 5
`define CIR_B_DAC2_POWER_ON 6
`define CIR_B_PORT2_AUTO_RATE 2
`define CIR_B_PORT2_SPEED_HI 1
`define CIR_B_PORT2_SPEED_LO 0
// ----------------------------------------
// timing
// ----------------------------------------
`define CIR_CLK_MHZ 250
`define CIR_HOLD_NS 300
`define CIR_SCL_LOW_MIN_NS 1300
`endif

// ### include/cir_pkg.sv
/*
 types shared by the control port modules.
 assumes cir_params.svh is on the include path.
*/
`include "cir_params.svh"
package cir_pkg;
   // one control register
   typedef logic [7:0] cir_byte_t;
   // register address counter
   typedef logic [4:0] cir_addr_t;
   // whole bank, index 0 in the low byte
   typedef cir_byte_t [`CIR_NUM_REGS-1:0] cir_regfile_t;
   // serial engine states
   typedef enum logic [2:0] {
      CIR_IDLE, CIR_ADDR, CIR_REG, CIR_WDATA, CIR_TX, CIR_SKIP
   } cir_state_t;
endpackage : cir_pkg

// ### include/cir_reg_if.sv
/*
 carrier between the serial engine and the register bank.
 assumes one clock domain; the bank answers reads combinationally.
*/
`timescale 1ns/1ns
`default_nettype none
interface cir_reg_if;
   import cir_pkg::*;
   logic wr_en; // one-cycle write strobe
   cir_addr_t addr; // write and read address
   cir_byte_t wdata; // write data
   cir_byte_t rdata; // read data at addr
   cir_regfile_t regs; // current register contents
   modport engine (output wr_en, output addr, output wdata, input rdata, input regs);
   modport bank (input wr_en, input addr, input wdata, output rdata, output regs);
endinterface : cir_reg_if
`default_nettype wire

// ### design/cir_line_sampler.sv
/*
 samples the bus clock and data lines, flags start, stop, clock rise,
 and a clock fall delayed by the data hold time.
 assumes both lines arrive synchronous to core_clk_in.
*/
`timescale 1ns/1ns
`default_nettype none
module cir_line_sampler #(
   parameter int HOLD_CYC = 75
) (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // bus lines
   input wire logic scl_in,
   input wire logic sda_in,
   // events
   output logic sda_bit_out,
   output logic scl_rise_out,
   output logic fall_dly_out,
   output logic start_out,
   output logic stop_out
);
   initial begin
      if (HOLD_CYC < 1 || HOLD_CYC > 255) $error("HOLD_CYC out of range");
   end
   logic scl_q, sda_q; // previous line levels
   logic [7:0] hold_cnt; // cycles left of data hold
   // ----------------------------------------
   // line history
   // ----------------------------------------
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_in;
         sda_q <= sda_in;
      end
   end
   assign sda_bit_out = sda_in;
   assign scl_rise_out = scl_in & ~scl_q;
   assign start_out = scl_in & scl_q & sda_q & ~sda_in;
   assign stop_out = scl_in & scl_q & ~sda_q & sda_in;
   // ----------------------------------------
   // delayed fall keeps data changes inside clock low
   // ----------------------------------------
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         hold_cnt <= 8'h00;
      end else if (~scl_in & scl_q) begin
         hold_cnt <= 8'(HOLD_CYC);
      end else if (hold_cnt != 8'h00) begin
         hold_cnt <= hold_cnt - 8'h01;
      end
   end
   assign fall_dly_out = (hold_cnt == 8'h01) & ~scl_in;
endmodule : cir_line_sampler
`default_nettype wire

// ### design/cir_reg_bank.sv
/*
 six 8-bit control registers with fixed-zero bits and reset values.
 assumes writes come as one-cycle strobes from the serial engine.
*/
`timescale 1ns/1ns
`default_nettype none
`include "cir_params.svh"
module cir_reg_bank (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_in,
   // engine side
   cir_reg_if.bank rif
);
   import cir_pkg::*;
   localparam cir_regfile_t RST_V = `CIR_RST_VALUES;
   localparam cir_regfile_t WR_M = `CIR_WR_MASKS;
   cir_regfile_t regs_q; // register storage
   // ----------------------------------------
   // storage, defaults while reset or power-down
   // ----------------------------------------
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         regs_q <= RST_V;
      end else if (rif.wr_en && rif.addr < 5'(`CIR_NUM_REGS)) begin
         // fixed-zero bits stay zero; timing reset bit leaves others alone
         regs_q[rif.addr[2:0]] <= rif.wdata & WR_M[rif.addr[2:0]];
      end
   end
   // ----------------------------------------
   // read answer, unmapped reads as zero
   // ----------------------------------------
   always_comb begin
      if (rif.addr < 5'(`CIR_NUM_REGS)) begin
         rif.rdata = regs_q[rif.addr[2:0]];
      end else begin
         rif.rdata = 8'h00;
      end
   end
   assign rif.regs = regs_q;
endmodule : cir_reg_bank
`default_nettype wire

// ### design/cir_codec_ctrl.sv
/*
 two-wire control port target of an audio codec with its register bank
 and the control levels that the bank steers.
 assumes an external open-drain wire resolves sda from sda_oe_n_out and
 that all inputs are synchronous to core_clk_in.
*/
// Behaviour
// - start is data falling, clock high
// - stop is data rising, clock high
// - data changes only while clock low
// - first byte address 00100 10 plus direction
// - acknowledge own address in ninth clock
// - second byte register address, top three ignored
// - acknowledge and store each write byte
// - write counter wraps after 05H to 00H
// - read counter wraps after 0DH to 00H
// - current read uses last address plus one
// - release after byte, sample controller acknowledge
// - power-down pin low restores register defaults
// - timing reset bit keeps register contents
// - register 00H layout, default 01H
// - unmute needs both pin high and bit
// - register 01H layout, default 70H
// - manual mode uses port-2 speed bits
// - auto mode uses detected clock speed
// - power bits zero power converters down
// - works at 400 kHz bus clock
`timescale 1ns/1ns
`default_nettype none
`include "cir_params.svh"
module cir_codec_ctrl (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire logic chip_powerdown_n_in,
   // two-wire bus
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n_out,
   // mute pins and detected clock speed
   input wire logic dac1_mute_pin_n_in,
   input wire logic dac2_mute_pin_n_in,
   input wire logic [1:0] port2_detected_speed_in,
   // control levels
   output logic timing_reset_n_out,
   output logic dac1_unmute_out,
   output logic dac2_unmute_out,
   output logic dac1_power_on_out,
   output logic dac2_power_on_out,
   output logic adc_power_on_out,
   output logic port2_auto_rate_out,
   output logic [1:0] port2_speed_out,
   output logic [3:0] serial_format_out,
   output logic [3:0] deemphasis_out,
   output logic [6:0] port1_clocking_out,
   output logic [6:0] input_select_out
);
   import cir_pkg::*;
   // ----------------------------------------
   // timing constants
   // ----------------------------------------
   // data hold after clock fall, rounded up to whole cycles
   localparam int HOLD_CYC = (`CIR_HOLD_NS * `CIR_CLK_MHZ + 999) / 1000;
   // shortest clock low at 400 kHz, rounded down
   localparam int SCL_LOW_CYC = (`CIR_SCL_LOW_MIN_NS * `CIR_CLK_MHZ) / 1000;
   initial begin
      // hold must end well before the controller may raise the clock
      if (HOLD_CYC >= SCL_LOW_CYC) $error("hold exceeds clock low");
   end

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   logic rst; // chip reset: reset input or power-down pin low
   logic sda_bit; // sampled data line
   logic scl_rise; // clock rising pulse
   logic fall_dly; // clock fall plus hold pulse
   logic start_ev; // start or repeated start
   logic stop_ev; // stop
   cir_state_t state; // engine state
   logic [3:0] bit_cnt; // clock rises in this byte
   logic in_ack; // own acknowledge being driven
   logic [7:0] shift_q; // received byte
   logic [7:0] tx_q; // byte being sent
   cir_addr_t addr_cnt; // register address counter
   logic ack_seen; // controller acknowledged last byte
   logic wr_en; // write strobe
   cir_byte_t wdata; // write data

   cir_reg_if rif ();

   // ----------------------------------------
   // address counter steps
   // ----------------------------------------
   function automatic cir_addr_t next_wr_addr(input cir_addr_t a);
      // wraps past the last writable register
      next_wr_addr = (a >= `CIR_WR_LAST) ? 5'h00 : a + 5'h01;
   endfunction : next_wr_addr

   function automatic cir_addr_t next_rd_addr(input cir_addr_t a);
      // wraps past the last readable address
      next_rd_addr = (a >= `CIR_RD_LAST) ? 5'h00 : a + 5'h01;
   endfunction : next_rd_addr

   // ----------------------------------------
   // submodules
   // ----------------------------------------
   assign rst = reset_in | ~chip_powerdown_n_in;

   cir_line_sampler #(
      .HOLD_CYC(HOLD_CYC)
   ) u_sampler (
      .core_clk_in(core_clk_in),
      .rst_in(rst),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .sda_bit_out(sda_bit),
      .scl_rise_out(scl_rise),
      .fall_dly_out(fall_dly),
      .start_out(start_ev),
      .stop_out(stop_ev)
   );

   cir_reg_bank u_bank (
      .core_clk_in(core_clk_in),
      .rst_in(rst),
      .rif(rif.bank)
   );

   assign rif.wr_en = wr_en;
   assign rif.addr = addr_cnt;
   assign rif.wdata = wdata;

   // ----------------------------------------
   // serial engine state
   // ----------------------------------------
   always_ff @(posedge core_clk_in) begin
      if (rst) begin
         state <= CIR_IDLE;
         in_ack <= 1'b0;
      end else if (start_ev) begin
         state <= CIR_ADDR;
         in_ack <= 1'b0;
      end else if (stop_ev) begin
         state <= CIR_IDLE;
         in_ack <= 1'b0;
      end else if (fall_dly) begin
         unique case (state)
            CIR_ADDR, CIR_REG, CIR_WDATA: begin
               if (in_ack) begin
                  // acknowledge slot over, pick the next phase
                  in_ack <= 1'b0;
                  if (state == CIR_ADDR) begin
                     state <= shift_q[0] ? CIR_TX : CIR_REG;
                  end else begin
                     state <= CIR_WDATA;
                  end
               end else if (bit_cnt == 4'h8) begin
                  if (state != CIR_ADDR || shift_q[7:1] == `CIR_TARGET_ADDR) begin
                     in_ack <= 1'b1;
                  end else begin
                     state <= CIR_SKIP;
                  end
               end
            end
            CIR_TX: begin
               // no acknowledge: stay off the bus until stop or start
               if (bit_cnt == 4'h9 && !ack_seen) begin
                  state <= CIR_SKIP;
               end
            end
            CIR_IDLE, CIR_SKIP: begin
               state <= state;
            end
         endcase
      end
   end

   // ----------------------------------------
   // bit counter and receive shifter
   // ----------------------------------------
   always_ff @(posedge core_clk_in) begin
      if (rst || start_ev || stop_ev) begin
         bit_cnt <= 4'h0;
         shift_q <= 8'h00;
      end else if (scl_rise && bit_cnt < 4'h9) begin
         bit_cnt <= bit_cnt + 4'h1;
         if (bit_cnt < 4'h8) begin
            shift_q <= {shift_q[6:0], sda_bit};
         end
      end else if (fall_dly && in_ack) begin
         bit_cnt <= 4'h0;
      end else if (fall_dly && state == CIR_TX && bit_cnt == 4'h9) begin
         bit_cnt <= 4'h0;
      end
   end

   // ----------------------------------------
   // controller acknowledge sample
   // ----------------------------------------
   always_ff @(posedge core_clk_in) begin
      if (rst) begin
         ack_seen <= 1'b0;
      end else if (scl_rise && state == CIR_TX && bit_cnt == 4'h8) begin
         ack_seen <= ~sda_bit;
      end
   end

   // ----------------------------------------
   // address counter and write strobe
   // ----------------------------------------
   always_ff @(posedge core_clk_in) begin
      if (rst) begin
         addr_cnt <= 5'h00;
         wr_en <= 1'b0;
         wdata <= 8'h00;
      end else begin
         wr_en <= 1'b0;
         if (fall_dly && !in_ack && bit_cnt == 4'h8) begin
            if (state == CIR_REG) begin
               addr_cnt <= shift_q[4:0];
            end else if (state == CIR_WDATA) begin
               wr_en <= 1'b1;
               wdata <= shift_q;
            end
         end
         if (wr_en) begin
            addr_cnt <= next_wr_addr(addr_cnt);
         end
         if (tx_load()) begin
            addr_cnt <= next_rd_addr(addr_cnt);
         end
      end
   end

   // a new byte is loaded when a read begins or is acknowledged
   function automatic logic tx_load();
      tx_load = fall_dly && ((state == CIR_ADDR && in_ack && shift_q[0]) ||
                (state == CIR_TX && bit_cnt == 4'h9 && ack_seen));
   endfunction : tx_load

   // ----------------------------------------
   // transmit shifter
   // ----------------------------------------
   always_ff @(posedge core_clk_in) begin
      if (rst) begin
         tx_q <= 8'hFF;
      end else if (tx_load()) begin
         tx_q <= rif.rdata;
      end else if (fall_dly && state == CIR_TX && bit_cnt < 4'h8) begin
         tx_q <= {tx_q[6:0], 1'b1};
      end
   end

   // ----------------------------------------
   // data line drive, set after the delayed fall, released at reset, start or stop
   // ----------------------------------------
   always_ff @(posedge core_clk_in) begin
      if (rst || start_ev || stop_ev) begin
         sda_oe_n_out <= 1'b1;
      end else if (fall_dly) begin
         if (tx_load()) begin
            sda_oe_n_out <= rif.rdata[7];
         end else if (state == CIR_TX && bit_cnt > 4'h0 && bit_cnt < 4'h8) begin
            sda_oe_n_out <= tx_q[6];
         end else if (!in_ack && bit_cnt == 4'h8 && state != CIR_TX &&
                      (state != CIR_ADDR || shift_q[7:1] == `CIR_TARGET_ADDR) &&
                      state != CIR_IDLE && state != CIR_SKIP) begin
            sda_oe_n_out <= 1'b0;
         end else begin
            sda_oe_n_out <= 1'b1;
         end
      end
   end

   // open-drain: only ever pulls low
   always_ff @(posedge core_clk_in) begin
      sda_out <= 1'b0;
   end

   // ----------------------------------------
   // control levels from the register bank
   // ----------------------------------------
   always_ff @(posedge core_clk_in) begin
      if (rst) begin
         timing_reset_n_out <= 1'b1;
         dac1_unmute_out <= 1'b0;
         dac2_unmute_out <= 1'b0;
         dac1_power_on_out <= 1'b1;
         dac2_power_on_out <= 1'b1;
         adc_power_on_out <= 1'b1;
         port2_auto_rate_out <= 1'b0;
         port2_speed_out <= 2'h0;
         serial_format_out <= 4'hF;
         deemphasis_out <= 4'h5;
         port1_clocking_out <= 7'h00;
         input_select_out <= 7'h10;
      end else begin
         timing_reset_n_out <= rif.regs[0][`CIR_B_TIMING_RESET_N];
         dac1_unmute_out <= dac1_mute_pin_n_in & rif.regs[0][`CIR_B_DAC1_UNMUTE];
         dac2_unmute_out <= dac2_mute_pin_n_in & rif.regs[0][`CIR_B_DAC2_UNMUTE];
         dac1_power_on_out <= rif.regs[1][`CIR_B_DAC1_POWER_ON];
         dac2_power_on_out <= rif.regs[1][`CIR_B_DAC2_POWER_ON];
         adc_power_on_out <= rif.regs[1][`CIR_B_ADC_POWER_ON];
         port2_auto_rate_out <= rif.regs[1][`CIR_B_PORT2_AUTO_RATE];
         if (rif.regs[1][`CIR_B_PORT2_AUTO_RATE]) begin
            port2_speed_out <= port2_detected_speed_in;
         end else begin
            port2_speed_out <= rif.regs[1][`CIR_B_PORT2_SPEED_HI:`CIR_B_PORT2_SPEED_LO];
         end
         serial_format_out <= rif.regs[2][3:0];
         deemphasis_out <= rif.regs[3][7:4];
         port1_clocking_out <= rif.regs[4][6:0];
         input_select_out <= rif.regs[5][6:0];
      end
   end
endmodule : cir_codec_ctrl
`default_nettype wire

// ### verif/cir_codec_ctrl_properties.sv
/* pin-level checks of the codec control port.
   assumes a bind onto cir_codec_ctrl with core_clk_in as the only clock. */
`timescale 1ns/1ns
`default_nettype none
module cir_codec_ctrl_properties (
   // clock and resets
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire logic chip_powerdown_n_in,
   // bus and pins
   input wire logic scl_in,
   input wire logic sda_out,
   input wire logic sda_oe_n_out,
   input wire logic dac1_mute_pin_n_in,
   input wire logic dac2_mute_pin_n_in,
   input wire logic [1:0] port2_detected_speed_in,
   // control levels
   input wire logic timing_reset_n_out,
   input wire logic dac1_unmute_out,
   input wire logic dac2_unmute_out,
   input wire logic dac1_power_on_out,
   input wire logic dac2_power_on_out,
   input wire logic adc_power_on_out,
   input wire logic port2_auto_rate_out,
   input wire logic [1:0] port2_speed_out,
   input wire logic [3:0] serial_format_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (reset_in);
   // ------------------------------
   // properties
   // ------------------------------
   property p_pd_release;
      !chip_powerdown_n_in |=> sda_oe_n_out;
   endproperty
   a_pd_release: assert property (p_pd_release) else $error("bus held in power-down");
   property p_pd_defaults;
      (!chip_powerdown_n_in) [*2] |=> timing_reset_n_out && !dac1_unmute_out && !dac2_unmute_out
         && dac1_power_on_out && dac2_power_on_out && adc_power_on_out && !port2_auto_rate_out
         && port2_speed_out == 2'h0 && serial_format_out == 4'hF;
   endproperty
   a_pd_defaults: assert property (p_pd_defaults) else $error("levels not at defaults");
   property p_mute1;
      !dac1_mute_pin_n_in |=> !dac1_unmute_out;
   endproperty
   a_mute1: assert property (p_mute1) else $error("dac1 unmuted with pin low");
   property p_mute2;
      !dac2_mute_pin_n_in |=> !dac2_unmute_out;
   endproperty
   a_mute2: assert property (p_mute2) else $error("dac2 unmuted with pin low");
   property p_auto;
      port2_auto_rate_out ##1 port2_auto_rate_out |-> port2_speed_out == $past(port2_detected_speed_in);
   endproperty
   a_auto: assert property (p_auto) else $error("auto speed not taken");
   property p_drive_low;
      $fell(sda_oe_n_out) |-> !scl_in && !$past(scl_in, 60);
   endproperty
   a_drive_low: assert property (p_drive_low) else $error("drive starts off clock low");
   property p_hold_fall;
      $fell(scl_in) |=> $stable(sda_oe_n_out) [*8];
   endproperty
   a_hold_fall: assert property (p_hold_fall) else $error("data hold broken");
   property p_drive_stands;
      !sda_oe_n_out && $rose(scl_in) |-> (!sda_oe_n_out) [*8];
   endproperty
   a_drive_stands: assert property (p_drive_stands) else $error("drive dropped in clock high");
   property p_open_drain;
      !sda_oe_n_out |-> !sda_out;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("driven level not low");
   // main scenarios seen
   c_drive: cover property ($fell(sda_oe_n_out));
   c_auto: cover property (port2_auto_rate_out ##1 port2_auto_rate_out);
   c_pd: cover property ((!chip_powerdown_n_in) [*2]);
endmodule : cir_codec_ctrl_properties
bind cir_codec_ctrl cir_codec_ctrl_properties u_props (
   .core_clk_in, .reset_in, .chip_powerdown_n_in, .scl_in, .sda_out, .sda_oe_n_out,
   .dac1_mute_pin_n_in, .dac2_mute_pin_n_in, .port2_detected_speed_in, .timing_reset_n_out,
   .dac1_unmute_out, .dac2_unmute_out, .dac1_power_on_out, .dac2_power_on_out,
   .adc_power_on_out, .port2_auto_rate_out, .port2_speed_out, .serial_format_out
);
`default_nettype wire

// ### verif/cir_bus_ctl_model.sv
/* two-wire bus controller: start, stop, byte out, byte in.
   assumes sda_in is the resolved wire with pull-up; moves after falling core edges.
   bus clock kept faster than fast mode to keep runs short. */
`timescale 1ns/1ns
`default_nettype none
module cir_bus_ctl_model #(
   parameter int HALF = 96 // core cycles per clock phase
) (
   // core clock
   input wire logic clk_in,
   // bus lines, 1 = released
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_out
);
   // idle bus at time zero
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   task automatic wt(input int n);
      repeat (n) @(negedge clk_in);
   endtask : wt
   // one clock pulse: data late in low phase, sample mid high
   task automatic bit_io(input logic b, output logic r);
      scl_out = 1'b0;
      wt(HALF - 16);
      sda_out = b;
      wt(16);
      scl_out = 1'b1;
      wt(HALF / 2);
      r = sda_in;
      wt(HALF / 2);
   endtask : bit_io
   // start, also repeated start
   task automatic start();
      logic r;
      bit_io(1'b1, r);
      sda_out = 1'b0;
      wt(HALF / 2);
   endtask : start
   task automatic stop();
      logic r;
      bit_io(1'b0, r);
      sda_out = 1'b1;
      wt(HALF);
   endtask : stop
   // byte out, msb first, then acknowledge slot
   task automatic send(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], r);
      end
      bit_io(1'b1, r);
      ack = ~r;
   endtask : send
   // byte in, then acknowledge when more is wanted
   task automatic recv(input logic more, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         b[i] = r;
      end
      bit_io(~more, r);
   endtask : recv
endmodule : cir_bus_ctl_model
`default_nettype wire

// ### verif/cir_codec_ctrl_tb_top.sv
/* self-checking bench of the codec control port with a register model.
   assumes design, package, checker and controller model compiled first. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
   $display("Error at %0t ns: got %0h expected %0h", $time, (a), (b)); end end
module cir_codec_ctrl_tb_top;
   // ------------------------------
   // pins and model state
   // ------------------------------
   logic core_clk_in = 1'b0;
   logic reset_in, pdn_n, m1_n, m2_n, scl, sda_ctl, ack;
   logic [1:0] det;
   wire logic sda_wire;
   logic sda_out, sda_oe_n_out, timing_reset_n_out, dac1_unmute_out, dac2_unmute_out;
   logic dac1_power_on_out, dac2_power_on_out, adc_power_on_out, port2_auto_rate_out;
   logic [1:0] port2_speed_out;
   logic [3:0] serial_format_out, deemphasis_out;
   logic [6:0] port1_clocking_out, input_select_out;
   logic [7:0] bad[3] = '{8'h26, 8'h64, 8'h27}; // foreign first bytes
   int dflt[$] = '{8'h01, 8'h70, 8'h0F, 8'h50, 8'h00, 8'h10};
   int msk[$] = '{8'h07, 8'h77, 8'h0F, 8'hF0, 8'h77, 8'h7F};
   int mdl[6];
   int ptr, seed, failures = 0, check_count = 0;
   // 250 MHz core clock
   always #2 core_clk_in = ~core_clk_in;
   // pull-up wire
   assign sda_wire = sda_ctl & (sda_oe_n_out | sda_out);
   cir_bus_ctl_model #(.HALF(96)) ctl (.clk_in(core_clk_in), .sda_in(sda_wire),
      .scl_out(scl), .sda_out(sda_ctl));
   cir_codec_ctrl dut (.core_clk_in, .reset_in, .chip_powerdown_n_in(pdn_n), .scl_in(scl),
      .sda_in(sda_wire), .sda_out, .sda_oe_n_out, .dac1_mute_pin_n_in(m1_n),
      .dac2_mute_pin_n_in(m2_n), .port2_detected_speed_in(det), .timing_reset_n_out,
      .dac1_unmute_out, .dac2_unmute_out, .dac1_power_on_out, .dac2_power_on_out,
      .adc_power_on_out, .port2_auto_rate_out, .port2_speed_out, .serial_format_out,
      .deemphasis_out, .port1_clocking_out, .input_select_out);
   // ------------------------------
   // tasks
   // ------------------------------
   task automatic mdl_def();
      foreach (mdl[i]) begin
         mdl[i] = dflt[i];
      end
      ptr = 0;
   endtask : mdl_def
   // write n bytes from register byte rb; d below zero picks random data
   task automatic wr_seq(input logic [7:0] rb, input int n, input int d, input logic fin);
      logic [7:0] v;
      ctl.start();
      ctl.send(8'h24, ack);
      `CHK(ack, 1'b1)
      ctl.send(rb, ack);
      `CHK(ack, 1'b1)
      ptr = rb & 8'h1F;
      for (int i = 0; i < n; i++) begin
         v = (d < 0) ? 8'($random(seed)) : 8'(d);
         v = v & 8'(msk[ptr]);
         ctl.send(v, ack);
         `CHK(ack, 1'b1)
         mdl[ptr] = v;
         ptr = (ptr >= 5) ? 0 : ptr + 1;
      end
      if (fin) begin
         ctl.stop();
      end
   endtask : wr_seq
   // read n bytes at the counter, last one not acknowledged
   task automatic rd_seq(input int n);
      logic [7:0] v;
      ctl.start();
      ctl.send(8'h25, ack);
      `CHK(ack, 1'b1)
      for (int i = 0; i < n; i++) begin
         ctl.recv(i < n - 1, v);
         `CHK(v, (ptr < 6) ? mdl[ptr] : 0)
         ptr = (ptr >= 13) ? 0 : ptr + 1;
      end
      ctl.stop();
   endtask : rd_seq
   // new random pin values, then all levels against the model
   task automatic chk_outs();
      logic [3:0] r;
      r = 4'($random(seed));
      m1_n = r[0];
      m2_n = r[1];
      det = r[3:2];
      repeat (4) @(negedge core_clk_in);
      `CHK(timing_reset_n_out, mdl[0][0])
      `CHK({dac2_unmute_out, dac1_unmute_out}, {m2_n, m1_n} & mdl[0][2:1])
      `CHK({dac2_power_on_out, dac1_power_on_out, adc_power_on_out}, mdl[1][6:4])
      `CHK(port2_auto_rate_out, mdl[1][2])
      `CHK(port2_speed_out, mdl[1][2] ? det : mdl[1][1:0])
      `CHK({deemphasis_out, serial_format_out}, {mdl[3][7:4], mdl[2][3:0]})
      `CHK({port1_clocking_out, input_select_out}, {mdl[4][6:0], mdl[5][6:0]})
   endtask : chk_outs
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : test_done
   // ------------------------------
   // main sequence and watchdog
   // ------------------------------
   initial begin
      seed = 97;
      reset_in = 1'b1;
      pdn_n = 1'b1;
      m1_n = 1'b1;
      m2_n = 1'b1;
      det = 2'h0;
      mdl_def();
      repeat (16) @(negedge core_clk_in);
      reset_in = 1'b0;
      chk_outs();
      rd_seq(6);
      $display("defaults done");
      wr_seq(8'hE4, 7, -1, 1'b1);
      chk_outs();
      rd_seq(2);
      $display("write wrap done");
      wr_seq(8'h0C, 0, 0, 1'b0);
      rd_seq(3);
      $display("random read done");
      foreach (bad[i]) begin
         ctl.start();
         ctl.send(bad[i], ack);
         `CHK(ack, 1'b0)
         ctl.stop();
      end
      rd_seq(1);
      $display("foreign address done");
      wr_seq(8'h00, 1, 8'h06, 1'b1);
      chk_outs();
      wr_seq(8'h01, 1, 8'h05, 1'b1);
      chk_outs();
      wr_seq(8'h01, 1, 8'h72, 1'b1);
      chk_outs();
      $display("levels done");
      pdn_n = 1'b0;
      mdl_def();
      chk_outs();
      pdn_n = 1'b1;
      rd_seq(6);
      $display("power-down done");
      test_done();
   end
   initial begin
      #380000; // run needs about 86k cycles
      failures++;
      $display("Error at %0t ns: watchdog expired", $time);
      test_done();
   end
endmodule : cir_codec_ctrl_tb_top
`default_nettype wire
